//--- avg_if.sv
// Carrier between the top module and its moving-average stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface avg_if #(parameter int DW = 16, parameter int NW = 5);
  logic sample_valid;
  logic signed [DW-1:0] sample;
  logic [NW-1:0] window;
  logic reload;
  logic signed [DW-1:0] average;
  logic average_valid;
  modport master (output sample_valid, output sample, output window, output reload,
                  input average, input average_valid);
  modport filter (input sample_valid, input sample, input window, input reload,
                  output average, output average_valid);
endinterface : avg_if

//--- host_clear_driver.sv
// Host-side driver of the deviation clear pin.
// Assumes the bench asks for one pulse at a time on the shared clock.
`timescale 1ns/1ps
module host_clear_driver (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Request from the bench
  input wire logic clr_go,
  input wire logic [7:0] clr_len,
  // Pin to the device
  output logic deviation_reset_input
);
  logic [7:0] hold_reg;
  // Short widths are how the bench probes the unqualified case
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_reg <= 8'h00;
    end else if (clr_go) begin
      hold_reg <= clr_len;
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end
  assign deviation_reset_input = (hold_reg != 8'h00);
endmodule : host_clear_driver

//--- moving_average.sv
// Moving-average stage over window + 1 most recent command samples.
// Assumes the window only changes together with reload, which empties the history.
`timescale 1ns/1ps
module moving_average #(
  parameter int DW = 16,
  parameter int NW = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Stream
  avg_if.filter port
);
  localparam int DEPTH = 1 << NW;
  localparam int SW = DW + NW + 1;

  logic signed [DW-1:0] hist_reg [DEPTH];
  logic signed [SW-1:0] sum_reg;
  logic signed [SW-1:0] sum_next;
  logic signed [DW-1:0] average_reg;
  logic average_valid_reg;

  // ----------------------------------------------------------------
  // Running sum: add newest, drop the one leaving the window
  // ----------------------------------------------------------------
  always_comb begin
    sum_next = sum_reg + SW'(port.sample) - SW'(hist_reg[port.window]);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_reg[i] <= '0;
      end
      sum_reg <= '0;
    end else if (port.reload) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_reg[i] <= '0;
      end
      sum_reg <= '0;
    end else if (port.sample_valid) begin
      hist_reg[0] <= port.sample;
      for (int i = 1; i < DEPTH; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
      sum_reg <= sum_next;
    end
  end

  // Divider is costly but runs once per sample; window is small
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      average_reg <= '0;
      average_valid_reg <= 1'b0;
    end else begin
      average_valid_reg <= port.sample_valid && !port.reload;
      if (port.sample_valid && !port.reload) begin
        average_reg <= DW'(sum_next / $signed({1'b0, SW'(port.window) + SW'(1)}));
      end
    end
  end

  assign port.average = average_reg;
  assign port.average_valid = average_valid_reg;

endmodule : moving_average

//--- servo_pkg.sv
// Constants, register map and mode codes for the servo smoothing and torque limit block.
// Assumes a single 25 MHz clock and the plain register port of the top module.
package servo_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WINDOW_PEND = 8'h00;
  localparam logic [7:0] ADDR_WINDOW_ACT = 8'h04;
  localparam logic [7:0] ADDR_RESET_MODE = 8'h08;
  localparam logic [7:0] ADDR_CEIL_FIRST = 8'h0C;
  localparam logic [7:0] ADDR_CEIL_SECOND = 8'h10;
  localparam logic [7:0] ADDR_CEIL_SELECT = 8'h14;
  localparam logic [7:0] ADDR_DEVIATION = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Field widths, limits and reset values
  // ----------------------------------------------------------------
  localparam int WINDOW_W = 5;
  localparam int PCT_W = 10;
  localparam logic [WINDOW_W-1:0] WINDOW_RESET = 5'h00;
  localparam logic [PCT_W-1:0] CEIL_RESET = 10'h1F4;
  localparam logic [PCT_W-1:0] CEIL_RANGE_MAX = 10'h1F4;
  localparam logic [PCT_W-1:0] PCT_FULL = 10'h064;
  localparam logic [PCT_W-1:0] OVERLOAD_PCT = 10'h12C;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_EDGE = 2'b01,
    MODE_OFF = 2'b10
  } reset_mode_type;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLR_MIN_US = 100;
  localparam int CLR_MIN_CYCLES = (CLR_MIN_US * (CLK_HZ / 1000000));

endpackage : servo_pkg

//--- servo_smoothing_torque_limit.sv
// Top of the command smoothing, deviation counter and torque ceiling block.
// Assumes command and feedback deltas come from same-clock logic; the clear input is a pin.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module servo_smoothing_torque_limit
  import servo_pkg::*;
#(
  parameter int CMD_W = 16,
  parameter int DEV_W = 32,
  parameter int TQ_W = 16,
  parameter int CLR_CYCLES = CLR_MIN_CYCLES,
  parameter logic [TQ_W-1:0] RATED_TORQUE = 16'h1000,
  parameter logic [PCT_W-1:0] MAX_TORQUE_PCT = OVERLOAD_PCT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control power-on event
  input wire logic power_on_pulse,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Position command and feedback
  input wire logic cmd_valid,
  input wire logic signed [CMD_W-1:0] cmd_delta,
  input wire logic fb_valid,
  input wire logic signed [CMD_W-1:0] fb_delta,
  output logic signed [CMD_W-1:0] smooth_cmd,
  output logic smooth_valid,
  output logic signed [DEV_W-1:0] deviation,
  // Deviation clear pin
  input wire logic deviation_reset_input,
  // Torque path
  input wire logic signed [TQ_W-1:0] torque_cmd,
  output logic signed [TQ_W-1:0] torque_out,
  output logic torque_limited
);

  localparam int CNT_W = $clog2(CLR_CYCLES + 1);
  localparam logic [CNT_W-1:0] CLR_DONE = CNT_W'(CLR_CYCLES);
  localparam int LIM_W = TQ_W + PCT_W;

  logic [WINDOW_W-1:0] window_pend_reg;
  logic [WINDOW_W-1:0] window_act_reg;
  reset_mode_type reset_mode_reg;
  logic [PCT_W-1:0] first_torque_ceiling_reg;
  logic [PCT_W-1:0] second_torque_ceiling_reg;
  logic torque_ceiling_select_reg;
  logic refused_reg;
  logic [31:0] rdata_reg;

  logic clr_meta_reg;
  logic clr_sync_reg;
  logic clr_prev_reg;
  logic [CNT_W-1:0] clr_cnt_reg;
  logic clr_qualified;
  logic clear_dev;
  logic signed [DEV_W-1:0] deviation_reg;

  logic [PCT_W-1:0] ceiling_pct;
  logic [LIM_W-1:0] limit_wide;
  logic signed [TQ_W:0] limit_pos;
  logic signed [TQ_W-1:0] torque_out_reg;
  logic torque_limited_reg;

  logic wr_bad_ceiling;
  logic wr_first;
  logic wr_second;
  logic wr_mode;

  avg_if #(.DW(CMD_W), .NW(WINDOW_W)) avg ();

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign wr_bad_ceiling = (reg_wdata > 32'(CEIL_RANGE_MAX)) ||
                          (reg_wdata > 32'(MAX_TORQUE_PCT));
  assign wr_first = reg_wr && (reg_addr == ADDR_CEIL_FIRST);
  assign wr_second = reg_wr && (reg_addr == ADDR_CEIL_SECOND);
  assign wr_mode = reg_wr && (reg_addr == ADDR_RESET_MODE);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      window_pend_reg <= WINDOW_RESET;
    end else if (reg_wr && (reg_addr == ADDR_WINDOW_PEND)) begin
      window_pend_reg <= reg_wdata[WINDOW_W-1:0];
    end
  end

  // Stored setting only reaches the filter at power-on
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      window_act_reg <= WINDOW_RESET;
    end else if (power_on_pulse) begin
      window_act_reg <= window_pend_reg;
    end
  end

  // Codes above the last mode are dropped rather than aliased
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_mode_reg <= MODE_EDGE;
    end else if (wr_mode && (reg_wdata <= 32'(MODE_OFF))) begin
      reset_mode_reg <= reset_mode_type'(reg_wdata[1:0]);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_torque_ceiling_reg <= CEIL_RESET;
      second_torque_ceiling_reg <= CEIL_RESET;
    end else begin
      if (wr_first && !wr_bad_ceiling) begin
        first_torque_ceiling_reg <= reg_wdata[PCT_W-1:0];
      end
      if (wr_second && !wr_bad_ceiling) begin
        second_torque_ceiling_reg <= reg_wdata[PCT_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      torque_ceiling_select_reg <= 1'b0;
    end else if (reg_wr && (reg_addr == ADDR_CEIL_SELECT)) begin
      torque_ceiling_select_reg <= reg_wdata[0];
    end
  end

  // Sticky refusal flag; writing the status register clears it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      refused_reg <= 1'b0;
    end else if ((wr_first || wr_second) && wr_bad_ceiling) begin
      refused_reg <= 1'b1;
    end else if (wr_mode && (reg_wdata > 32'(MODE_OFF))) begin
      refused_reg <= 1'b1;
    end else if (reg_wr && (reg_addr == ADDR_STATUS)) begin
      refused_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_WINDOW_PEND: rdata_reg <= 32'(window_pend_reg);
        ADDR_WINDOW_ACT: rdata_reg <= 32'(window_act_reg);
        ADDR_RESET_MODE: rdata_reg <= 32'(reset_mode_reg);
        ADDR_CEIL_FIRST: rdata_reg <= 32'(first_torque_ceiling_reg);
        ADDR_CEIL_SECOND: rdata_reg <= 32'(second_torque_ceiling_reg);
        ADDR_CEIL_SELECT: rdata_reg <= 32'(torque_ceiling_select_reg);
        ADDR_DEVIATION: rdata_reg <= 32'(deviation_reg);
        ADDR_STATUS: rdata_reg <= {29'h0, clr_sync_reg, torque_limited_reg, refused_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Command smoothing
  // ----------------------------------------------------------------
  assign avg.sample_valid = cmd_valid;
  assign avg.sample = cmd_delta;
  assign avg.window = window_act_reg;
  assign avg.reload = power_on_pulse;

  moving_average #(.DW(CMD_W), .NW(WINDOW_W)) u_avg (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .port(avg.filter)
  );

  assign smooth_cmd = avg.average;
  assign smooth_valid = avg.average_valid;

  // ----------------------------------------------------------------
  // Deviation clear input
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_meta_reg <= 1'b0;
      clr_sync_reg <= 1'b0;
      clr_prev_reg <= 1'b0;
    end else begin
      clr_meta_reg <= deviation_reset_input;
      clr_sync_reg <= clr_meta_reg;
      clr_prev_reg <= clr_sync_reg;
    end
  end

  // Width counter saturates; shorter pulses are treated as noise
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_cnt_reg <= '0;
    end else if (!clr_sync_reg) begin
      clr_cnt_reg <= '0;
    end else if (clr_cnt_reg != CLR_DONE) begin
      clr_cnt_reg <= clr_cnt_reg + CNT_W'(1);
    end
  end

  assign clr_qualified = (clr_cnt_reg == CLR_DONE);

  always_comb begin
    unique case (reset_mode_reg)
      MODE_HOLD: clear_dev = clr_qualified;
      MODE_EDGE: clear_dev = clr_prev_reg && !clr_sync_reg && clr_qualified;
      MODE_OFF: clear_dev = 1'b0;
      default: clear_dev = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Deviation counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      deviation_reg <= '0;
    end else if (clear_dev) begin
      deviation_reg <= '0;
    end else begin
      deviation_reg <= deviation_reg
        + (smooth_valid ? DEV_W'(smooth_cmd) : DEV_W'(0))
        - (fb_valid ? DEV_W'(fb_delta) : DEV_W'(0));
    end
  end

  assign deviation = deviation_reg;

  // ----------------------------------------------------------------
  // Torque ceiling
  // ----------------------------------------------------------------
  always_comb begin
    ceiling_pct = torque_ceiling_select_reg ? second_torque_ceiling_reg
                                            : first_torque_ceiling_reg;
    if (ceiling_pct > MAX_TORQUE_PCT) begin
      ceiling_pct = MAX_TORQUE_PCT;
    end
    limit_wide = (LIM_W'(RATED_TORQUE) * LIM_W'(ceiling_pct)) / LIM_W'(PCT_FULL);
    if (limit_wide > LIM_W'({1'b0, {(TQ_W-1){1'b1}}})) begin
      limit_pos = (TQ_W+1)'({1'b0, {(TQ_W-1){1'b1}}});
    end else begin
      limit_pos = (TQ_W+1)'(limit_wide);
    end
  end

  // Same magnitude on both sides of zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      torque_out_reg <= '0;
      torque_limited_reg <= 1'b0;
    end else if ((TQ_W+1)'(torque_cmd) > limit_pos) begin
      torque_out_reg <= TQ_W'(limit_pos);
      torque_limited_reg <= 1'b1;
    end else if ((TQ_W+1)'(torque_cmd) < -limit_pos) begin
      torque_out_reg <= TQ_W'(-limit_pos);
      torque_limited_reg <= 1'b1;
    end else begin
      torque_out_reg <= torque_cmd;
      torque_limited_reg <= 1'b0;
    end
  end

  assign torque_out = torque_out_reg;
  assign torque_limited = torque_limited_reg;

endmodule : servo_smoothing_torque_limit

//--- servo_smoothing_torque_limit_properties.sv
// Concurrent checks on the top ports of the smoothing and torque ceiling block.
// Assumes it is bound to the top module and shares its single clock and reset.
`timescale 1ns/1ps
module servo_smoothing_torque_limit_properties
  import servo_pkg::*;
#(
  parameter int CMD_W = 16,
  parameter int DEV_W = 32,
  parameter int TQ_W = 16,
  parameter logic [TQ_W-1:0] RATED_TORQUE = 16'h1000,
  parameter logic [PCT_W-1:0] MAX_TORQUE_PCT = OVERLOAD_PCT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic power_on_pulse,
  input wire logic fb_valid,
  input wire logic signed [CMD_W-1:0] fb_delta,
  input wire logic signed [CMD_W-1:0] smooth_cmd,
  input wire logic smooth_valid,
  input wire logic signed [DEV_W-1:0] deviation,
  input wire logic deviation_reset_input,
  input wire logic signed [TQ_W-1:0] torque_cmd,
  input wire logic signed [TQ_W-1:0] torque_out,
  input wire logic torque_limited
);
  // Fixed ceiling: no register setting may lift the output above it
  localparam int LIM = int'(RATED_TORQUE) * int'(MAX_TORQUE_PCT) / int'(PCT_FULL);
  logic signed [DEV_W-1:0] step;
  assign step = (smooth_valid ? DEV_W'(smooth_cmd) : DEV_W'(0))
    - (fb_valid ? DEV_W'(fb_delta) : DEV_W'(0));
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Long enough for a falling-edge clear to have landed
  sequence pin_idle;
    !deviation_reset_input [*8];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  a_torque_cap: assert property (torque_out <= LIM && torque_out >= -LIM)
    else $error("torque above fixed maximum");
  a_torque_pass: assert property (!torque_limited |-> torque_out == $past(torque_cmd))
    else $error("unclamped torque differs from request");
  a_clamp_neg: assert property (torque_limited && $past(torque_cmd) < 0 |->
    torque_out <= 0 && torque_out > $past(torque_cmd))
    else $error("negative clamp wrong");
  a_clamp_pos: assert property (torque_limited && $past(torque_cmd) > 0 |->
    torque_out >= 0 && torque_out < $past(torque_cmd))
    else $error("positive clamp wrong");
  a_smooth_lat: assert property (cmd_valid && !power_on_pulse |=> smooth_valid)
    else $error("no average after sample");
  a_smooth_src: assert property (smooth_valid |-> $past(cmd_valid))
    else $error("average without sample");
  a_dev_step: assert property (pin_idle |=> deviation == $past(deviation) + $past(step))
    else $error("deviation changed without cause");
endmodule : servo_smoothing_torque_limit_properties

bind servo_smoothing_torque_limit servo_smoothing_torque_limit_properties #(.CMD_W(CMD_W),
  .DEV_W(DEV_W), .TQ_W(TQ_W), .RATED_TORQUE(RATED_TORQUE), .MAX_TORQUE_PCT(MAX_TORQUE_PCT))
  i_servo_smoothing_torque_limit_properties (.ref_clk, .rst_b, .reg_rd, .reg_rdata, .cmd_valid,
  .power_on_pulse, .fb_valid, .fb_delta, .smooth_cmd, .smooth_valid, .deviation,
  .deviation_reset_input, .torque_cmd, .torque_out, .torque_limited);

//--- test_servo_smoothing_torque_limit.sv
// Self-checking bench for the smoothing, deviation and torque ceiling block.
// Assumes the host clear driver model and the bound property checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s expected %0d seen %0d", n, e, g); end end
module test_servo_smoothing_torque_limit;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic power_on_pulse = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic cmd_valid = 1'b0;
  logic signed [15:0] cmd_delta = 16'h0000;
  logic fb_valid = 1'b0;
  logic signed [15:0] fb_delta = 16'h0000;
  logic signed [15:0] smooth_cmd;
  logic smooth_valid;
  logic signed [31:0] deviation;
  logic deviation_reset_input;
  logic signed [15:0] torque_cmd = 16'h0000;
  logic signed [15:0] torque_out;
  logic torque_limited;
  logic clr_go = 1'b0;
  logic [7:0] clr_len = 8'h00;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] rst_addr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [31:0] rst_val [9] = '{32'h0, 32'h0, 32'h1, 32'h1F4, 32'h1F4, 32'h0, 32'h0, 32'h0, 32'h0};
  servo_smoothing_torque_limit #(.CLR_CYCLES(8)) i_servo_smoothing_torque_limit (.ref_clk, .rst_b,
    .power_on_pulse, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd_delta,
    .fb_valid, .fb_delta, .smooth_cmd, .smooth_valid, .deviation, .deviation_reset_input,
    .torque_cmd, .torque_out, .torque_limited);
  host_clear_driver i_host_clear_driver (.ref_clk, .rst_b, .clr_go, .clr_len,
    .deviation_reset_input);
  always #20 ref_clk = ~ref_clk;
  // Whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  task automatic tq(input logic signed [15:0] v, input logic signed [15:0] e);
    @(posedge ref_clk);
    torque_cmd <= v;
    @(posedge ref_clk);
    #1;
    `CHK("torque_out", e, torque_out)
  endtask : tq
  task automatic cmd(input logic signed [15:0] v);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_delta <= v;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : cmd
  task automatic fb(input logic signed [15:0] v);
    @(posedge ref_clk);
    fb_valid <= 1'b1;
    fb_delta <= v;
    @(posedge ref_clk);
    fb_valid <= 1'b0;
  endtask : fb
  task automatic clr(input logic [7:0] n);
    @(posedge ref_clk);
    clr_go <= 1'b1;
    clr_len <= n;
    @(posedge ref_clk);
    clr_go <= 1'b0;
  endtask : clr
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(rst_addr[i], rst_val[i]);
    end
    // Window change waits for power-on
    wr(8'h00, 32'h3);
    rd(8'h04, 32'h0);
    cmd(16'sd10);
    `CHK("smooth_cmd", 16'sd10, smooth_cmd)
    `CHK("smooth_valid", 1'b1, smooth_valid)
    @(posedge ref_clk);
    power_on_pulse <= 1'b1;
    @(posedge ref_clk);
    power_on_pulse <= 1'b0;
    rd(8'h04, 32'h3);
    for (int i = 1; i <= 5; i++) begin
      cmd(16'(4 * i));
    end
    `CHK("smooth_cmd", 16'sd14, smooth_cmd)
    `CHK("smooth_valid", 1'b1, smooth_valid)
    // Deviation gathers every average: 10 + 1 + 3 + 6 + 10 + 14
    rd(8'h18, 32'h2C);
    // Clear modes: edge, too short, ignored, refused code, level hold
    clr(8'h14);
    idle(30);
    `CHK("deviation", 32'sd0, deviation)
    fb(16'sd5);
    clr(8'h03);
    idle(14);
    `CHK("deviation", -32'sd5, deviation)
    wr(8'h08, 32'h2);
    clr(8'h14);
    idle(30);
    `CHK("deviation", -32'sd5, deviation)
    wr(8'h08, 32'h3);
    rd(8'h08, 32'h2);
    rd(8'h1C, 32'h1);
    wr(8'h08, 32'h0);
    clr(8'h28);
    idle(16);
    fb(16'sd5);
    idle(2);
    `CHK("deviation", 32'sd0, deviation)
    idle(30);
    // Torque ceilings; clear the refusal left by the mode write first
    wr(8'h1C, 32'h0);
    rd(8'h1C, 32'h0);
    wr(8'h0C, 32'h12D);
    wr(8'h0C, 32'h258);
    rd(8'h0C, 32'h1F4);
    rd(8'h1C, 32'h1);
    wr(8'h0C, 32'h96);
    tq(16'sd8000, 16'sd6144);
    `CHK("torque_limited", 1'b1, torque_limited)
    tq(-16'sd8000, -16'sd6144);
    tq(16'sd100, 16'sd100);
    `CHK("torque_limited", 1'b0, torque_limited)
    wr(8'h14, 32'h1);
    tq(16'sd20000, 16'sd12288);
    wr(8'h10, 32'h0);
    tq(-16'sd50, 16'sd0);
    complete_run();
  end
endmodule : test_servo_smoothing_torque_limit
